// file: shared/pbth_pkg.sv
// Purpose: Constants and types for the bridge termination handler
// Assumes: Single 50 MHz clock, synchronous active-high reset
// Notes:   Register offsets are byte addresses on a simple register port
package pbth_pkg;
  localparam logic [7:0]  PBTH_REG_EVT_MASK  = 8'h64;
  localparam logic [7:0]  PBTH_REG_CMD       = 8'h04;
  localparam logic [7:0]  PBTH_REG_STATUS    = 8'h08;
  localparam logic [7:0]  PBTH_REG_LIMIT     = 8'h0c;
  localparam logic [7:0]  PBTH_REG_ATTEMPTS  = 8'h10;
  localparam int          PBTH_CMD_SERR_EN_BIT = 8;
  localparam int          PBTH_MASK_PW_BIT     = 2;
  localparam int          PBTH_MASK_DLY_BIT    = 5;
  localparam logic [7:0]  PBTH_MASK_RESET    = 8'h00;
  localparam logic [15:0] PBTH_CMD_RESET     = 16'h0000;
  localparam logic [31:0] PBTH_LIMIT_DEFAULT = 32'h0100_0000;
  localparam int          PBTH_ST_RX_TABORT  = 0;
  localparam int          PBTH_ST_SIG_TABORT = 1;
  localparam int          PBTH_ST_SIG_SERR   = 2;
  localparam int          PBTH_ST_RX_MABORT  = 3;
  localparam int          PBTH_DEVSEL_CLOCKS = 5;
  localparam int          PBTH_ACCEPT_CLOCKS = 16;
  localparam logic [3:0]  PBTH_CMD_MEM_WRITE = 4'h7;
  localparam logic [3:0]  PBTH_CMD_MWI       = 4'hf;

  typedef enum logic [1:0] {PBTH_KIND_DW, PBTH_KIND_PW, PBTH_KIND_DR} pbth_kind_t;
  typedef enum logic [2:0] {PBTH_TT_NONE, PBTH_TT_NORMAL, PBTH_TT_RETRY,
                            PBTH_TT_DISC, PBTH_TT_TABORT, PBTH_TT_MABORT} pbth_term_t;
  typedef enum logic [2:0] {PBTH_RSP_NONE, PBTH_RSP_DATA, PBTH_RSP_DATA_DISC,
                            PBTH_RSP_RETRY, PBTH_RSP_DISC, PBTH_RSP_TABORT,
                            PBTH_RSP_NODEVSEL} pbth_resp_t;
endpackage

// file: logic/pbth_handler.sv
// Purpose: Termination handling for a two-port PCI bridge
// Assumes: Bus state machines outside present decoded terminations as pulses
// Notes:   Attempt counting per queue entry, system error gating, initiator replies
`timescale 1ns/1ns

// How it works
// - Delayed write reissued until data, abort
// - Retry attempts bounded by configurable limit
// - Delayed write done: disconnect if multi-phase
// - Target retry on delayed write: retry initiator
// - Delayed write abort: relay, set both flags
// - Delayed write exhausted: system error if enabled
// - Posted retry reissues same address
// - Posted disconnect restarts at next DWORD
// - Partial invalidate write continues as write
// - Posted abort: flag, system error if enabled
// - Posted exhausted: system error if enabled
// - Delayed read reissued until data, abort
// - Read done: prefetch versus first-phase disconnect
// - Read disconnect passed on if more wanted
// - Delayed read abort: relay, set both flags
// - Delayed read exhausted: system error if enabled
// - Delayed write retried while busy or blocked
// - Delayed read retried while data unready
// - Posted write retried without room, lock
// - Unrepeated delayed transaction discarded on timeout
// - Disconnect on boundary, full, no data
// - Target abort only relayed, flags set
// - Master abort after five clocks without select
module pbth_handler
  import pbth_pkg::*;
#(
  parameter int          ENTRIES     = 4,
  parameter logic [31:0] RETRY_LIMIT = PBTH_LIMIT_DEFAULT,
  parameter int          MTO_CLOCKS  = 32768
) (
  input  wire logic                       clock_i,
  input  wire logic                       srst_i,
  // Register port
  input  wire logic [7:0]                 reg_addr_i,
  input  wire logic [31:0]                reg_wdata_i,
  input  wire logic                       reg_write_i,
  input  wire logic                       reg_read_i,
  output logic      [31:0]                reg_rdata_o,
  // Target-bus side: attempt outcome for a queue entry
  input  wire logic                       tgt_start_i,
  input  wire logic                       tgt_devsel_i,
  input  wire logic                       tgt_end_i,
  input  wire pbth_term_t                 tgt_term_i,
  input  wire logic [$clog2(ENTRIES)-1:0] tgt_entry_i,
  input  wire pbth_kind_t                 tgt_kind_i,
  input  wire logic [31:0]                tgt_addr_i,
  input  wire logic [3:0]                 tgt_cmd_i,
  input  wire logic [15:0]                tgt_dwords_i,
  input  wire logic                       tgt_left_i,
  output logic                            tgt_reissue_o,
  output logic      [31:0]                tgt_next_addr_o,
  output logic      [3:0]                 tgt_next_cmd_o,
  output logic                            tgt_mabort_o,
  // Initiator side: request and reply decision
  input  wire logic                       ini_req_i,
  input  wire pbth_kind_t                 ini_kind_i,
  input  wire logic [$clog2(ENTRIES)-1:0] ini_entry_i,
  input  wire logic                       ini_multi_i,
  input  wire logic                       ini_prefetch_i,
  input  wire logic                       ini_more_i,
  input  wire logic                       ini_queueing_i,
  input  wire logic                       ini_not_ready_i,
  input  wire logic                       ini_queue_full_i,
  input  wire logic                       ini_dup_i,
  input  wire logic                       ini_lock_conflict_i,
  input  wire logic                       ini_behind_post_i,
  input  wire logic                       ini_discarding_i,
  input  wire logic                       ini_pw_room_i,
  input  wire logic                       ini_boundary_i,
  input  wire logic                       ini_no_space_i,
  input  wire logic                       ini_no_data_i,
  input  wire logic [4:0]                 ini_accept_clocks_i,
  output pbth_resp_t                      ini_resp_o,
  output logic                            ini_entry_drop_o,
  output logic                            primary_system_error_out
);
  localparam int EW = $clog2(ENTRIES);

  logic [7:0]        mask_q;
  logic [15:0]       cmd_q;
  logic [31:0]       limit_q;
  logic [3:0]        status_q;
  logic              serr_q;
  logic [31:0]       cnt_q    [ENTRIES];
  pbth_term_t        result_q [ENTRIES];
  logic              valid_q  [ENTRIES];
  logic [15:0]       mto_q    [ENTRIES];
  logic [2:0]        dsel_q;
  logic              dsel_wait_q;
  logic [31:0]       rdata_d;

  wire serr_en   = cmd_q[PBTH_CMD_SERR_EN_BIT];
  wire dly_ok    = serr_en && !mask_q[PBTH_MASK_DLY_BIT];
  wire pw_ok     = serr_en && !mask_q[PBTH_MASK_PW_BIT];
  wire retry_end = tgt_end_i && tgt_term_i == PBTH_TT_RETRY;
  wire exhausted = cnt_q[tgt_entry_i] + 32'h1 >= limit_q;
  wire got_abort = tgt_end_i && tgt_term_i == PBTH_TT_TABORT;
  wire ini_abort = ini_req_i && ini_kind_i != PBTH_KIND_PW
                   && valid_q[ini_entry_i] && result_q[ini_entry_i] == PBTH_TT_TABORT;

  // Registers written by software
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      mask_q  <= PBTH_MASK_RESET;
      cmd_q   <= PBTH_CMD_RESET;
      limit_q <= RETRY_LIMIT;
    end else if (reg_write_i) begin
      unique case (reg_addr_i)
        PBTH_REG_EVT_MASK: mask_q  <= reg_wdata_i[7:0];
        PBTH_REG_CMD:      cmd_q   <= reg_wdata_i[15:0];
        PBTH_REG_LIMIT:    limit_q <= (reg_wdata_i == 32'h0) ? 32'h1 : reg_wdata_i;
        default: ;
      endcase
    end
  end

  // Status flags: write one to clear, a new event wins over the clear
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      status_q <= 4'h0;
    end else begin
      for (int b = 0; b < 4; b++) begin
        if (reg_write_i && reg_addr_i == PBTH_REG_STATUS && reg_wdata_i[b])
          status_q[b] <= 1'b0;
      end
      if (got_abort)
        status_q[PBTH_ST_RX_TABORT] <= 1'b1;
      if (ini_abort)
        status_q[PBTH_ST_SIG_TABORT] <= 1'b1;
      if (tgt_mabort_o)
        status_q[PBTH_ST_RX_MABORT] <= 1'b1;
      if (serr_q)
        status_q[PBTH_ST_SIG_SERR] <= 1'b1;
    end
  end

  // System error is a one-cycle pulse per event
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      serr_q <= 1'b0;
    end else begin
      serr_q <= 1'b0;
      if (retry_end && exhausted) begin
        if (tgt_kind_i == PBTH_KIND_PW)
          serr_q <= pw_ok;
        else
          serr_q <= dly_ok;
      end
      if (got_abort && tgt_kind_i == PBTH_KIND_PW)
        serr_q <= serr_en;
    end
  end
  assign primary_system_error_out = serr_q;

  // Master abort: no device select within five clocks of frame
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      dsel_q      <= 3'h0;
      dsel_wait_q <= 1'b0;
    end else if (tgt_start_i) begin
      dsel_q      <= 3'h0;
      dsel_wait_q <= 1'b1;
    end else if (dsel_wait_q) begin
      if (tgt_devsel_i)
        dsel_wait_q <= 1'b0;
      else if (dsel_q == 3'(PBTH_DEVSEL_CLOCKS - 1))
        dsel_wait_q <= 1'b0;
      else
        dsel_q <= dsel_q + 3'h1;
    end
  end
  assign tgt_mabort_o = dsel_wait_q && !tgt_devsel_i
                        && dsel_q == 3'(PBTH_DEVSEL_CLOCKS - 1);

  // Per-entry attempt counters, results and repeat timers
  generate
    for (genvar e = 0; e < ENTRIES; e++) begin : g_entry
      wire hit_t = tgt_end_i && tgt_entry_i == EW'(e);
      wire hit_i = ini_req_i && ini_entry_i == EW'(e);
      wire done  = hit_i && valid_q[e];
      wire tmo   = valid_q[e] && mto_q[e] == 16'(MTO_CLOCKS - 1);
      always_ff @(posedge clock_i) begin
        if (srst_i) begin
          cnt_q[e]    <= 32'h0;
          result_q[e] <= PBTH_TT_NONE;
          valid_q[e]  <= 1'b0;
          mto_q[e]    <= 16'h0;
        end else if (tmo) begin
          cnt_q[e]    <= 32'h0;
          valid_q[e]  <= 1'b0;
          result_q[e] <= PBTH_TT_NONE;
        end else if (hit_t) begin
          if (tgt_term_i == PBTH_TT_RETRY) begin
            cnt_q[e] <= exhausted ? 32'h0 : cnt_q[e] + 32'h1;
          end else begin
            cnt_q[e]    <= 32'h0;
            result_q[e] <= tgt_term_i;
            valid_q[e]  <= tgt_kind_i != PBTH_KIND_PW;
            mto_q[e]    <= 16'h0;
          end
        end else if (done) begin
          valid_q[e]  <= 1'b0;
          result_q[e] <= PBTH_TT_NONE;
        end else if (valid_q[e]) begin
          mto_q[e] <= mto_q[e] + 16'h1;
        end
      end
    end
  endgenerate

  // Reissue decisions toward the target bus
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      tgt_reissue_o   <= 1'b0;
      tgt_next_addr_o <= 32'h0;
      tgt_next_cmd_o  <= 4'h0;
    end else begin
      tgt_reissue_o <= 1'b0;
      if (retry_end && !exhausted) begin
        tgt_reissue_o   <= 1'b1;
        tgt_next_addr_o <= tgt_addr_i;
        tgt_next_cmd_o  <= tgt_cmd_i;
      end else if (tgt_end_i && tgt_term_i == PBTH_TT_DISC
                   && tgt_kind_i == PBTH_KIND_PW && tgt_left_i) begin
        tgt_reissue_o   <= 1'b1;
        tgt_next_addr_o <= tgt_addr_i + {14'h0, tgt_dwords_i, 2'b00};
        tgt_next_cmd_o  <= (tgt_cmd_i == PBTH_CMD_MWI && tgt_dwords_i != 16'h0)
                           ? PBTH_CMD_MEM_WRITE : tgt_cmd_i;
      end
    end
  end

  // Reply to the originating initiator
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      ini_resp_o       <= PBTH_RSP_NONE;
      ini_entry_drop_o <= 1'b0;
    end else begin
      ini_entry_drop_o <= 1'b0;
      ini_resp_o       <= PBTH_RSP_NONE;
      if (ini_req_i) begin
        unique case (ini_kind_i)
          PBTH_KIND_PW: begin
            if (!ini_pw_room_i || ini_lock_conflict_i)
              ini_resp_o <= PBTH_RSP_RETRY;
            else if (ini_boundary_i || ini_no_space_i)
              ini_resp_o <= PBTH_RSP_DATA_DISC;
            else
              ini_resp_o <= PBTH_RSP_DATA;
          end
          PBTH_KIND_DW: begin
            if (ini_queueing_i || ini_not_ready_i || ini_queue_full_i || ini_dup_i
                || ini_lock_conflict_i || ini_accept_clocks_i > 5'(PBTH_ACCEPT_CLOCKS)
                || !valid_q[ini_entry_i])
              ini_resp_o <= PBTH_RSP_RETRY;
            else begin
              ini_entry_drop_o <= 1'b1;
              unique case (result_q[ini_entry_i])
                PBTH_TT_TABORT: ini_resp_o <= PBTH_RSP_TABORT;
                PBTH_TT_MABORT: ini_resp_o <= PBTH_RSP_NODEVSEL;
                default: ini_resp_o <= (ini_multi_i || ini_boundary_i)
                                       ? PBTH_RSP_DATA_DISC : PBTH_RSP_DATA;
              endcase
            end
          end
          PBTH_KIND_DR: begin
            if (ini_queueing_i || ini_not_ready_i || ini_behind_post_i || ini_queue_full_i
                || ini_dup_i || ini_lock_conflict_i || ini_discarding_i
                || !valid_q[ini_entry_i])
              ini_resp_o <= PBTH_RSP_RETRY;
            else begin
              ini_entry_drop_o <= 1'b1;
              unique case (result_q[ini_entry_i])
                PBTH_TT_TABORT: ini_resp_o <= PBTH_RSP_TABORT;
                PBTH_TT_MABORT: ini_resp_o <= PBTH_RSP_NODEVSEL;
                PBTH_TT_DISC:   ini_resp_o <= (ini_more_i || ini_no_data_i)
                                              ? PBTH_RSP_DATA_DISC : PBTH_RSP_DATA;
                default: ini_resp_o <= (ini_prefetch_i ? (ini_more_i || ini_boundary_i)
                                                       : ini_multi_i)
                                       ? PBTH_RSP_DATA_DISC : PBTH_RSP_DATA;
              endcase
            end
          end
          default: ini_resp_o <= PBTH_RSP_NONE;
        endcase
      end
    end
  end

  // Read back
  always_comb begin
    rdata_d = 32'h0;
    unique case (reg_addr_i)
      PBTH_REG_EVT_MASK: rdata_d = {24'h0, mask_q};
      PBTH_REG_CMD:      rdata_d = {16'h0, cmd_q};
      PBTH_REG_STATUS:   rdata_d = {28'h0, status_q};
      PBTH_REG_LIMIT:    rdata_d = limit_q;
      PBTH_REG_ATTEMPTS: rdata_d = cnt_q[0];
      default:           rdata_d = 32'h0;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (srst_i)
      reg_rdata_o <= 32'h0;
    else
      reg_rdata_o <= reg_read_i ? rdata_d : 32'h0;
  end
endmodule // pbth_handler

// file: sim/pbth_handler_chk.sv
// Purpose: Concurrent checks on the termination handler ports
// Assumes: One clock domain, srst_i synchronous and active high
// Notes:   Sees a subset of the top ports; bound below
`timescale 1ns/1ns
module pbth_handler_chk
  import pbth_pkg::*;
(
  input wire logic        clock_i, srst_i, reg_read_i, tgt_start_i, tgt_devsel_i, tgt_end_i, tgt_left_i,
  input wire logic        tgt_reissue_o, tgt_mabort_o, ini_req_i, ini_queueing_i, ini_queue_full_i,
  input wire logic        ini_dup_i, ini_lock_conflict_i, ini_pw_room_i, primary_system_error_out,
  input wire logic [31:0] reg_rdata_o, tgt_addr_i, tgt_next_addr_o,
  input wire logic [3:0]  tgt_cmd_i, tgt_next_cmd_o,
  input wire logic [15:0] tgt_dwords_i,
  input wire logic [4:0]  ini_accept_clocks_i,
  input wire pbth_term_t  tgt_term_i,
  input wire pbth_kind_t  tgt_kind_i, ini_kind_i,
  input wire pbth_resp_t  ini_resp_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);
  wire pw_end = tgt_end_i && tgt_kind_i == PBTH_KIND_PW;
  wire dw_busy = ini_queueing_i || ini_queue_full_i || ini_dup_i || ini_lock_conflict_i || ini_accept_clocks_i > 5'd16;
  sequence s_no_select;
    tgt_start_i && !tgt_devsel_i ##1 !tgt_devsel_i [*5];
  endsequence
  a_mabort_fifth: assert property (s_no_select |-> tgt_mabort_o)
    else $error("no master abort on fifth unselected cycle");
  a_mabort_selected: assert property (tgt_start_i ##1 tgt_devsel_i |-> !tgt_mabort_o [*5])
    else $error("master abort while selected");
  a_retry_same_addr: assert property (pw_end && tgt_term_i == PBTH_TT_RETRY |=>
    tgt_reissue_o && tgt_next_addr_o == $past(tgt_addr_i) || primary_system_error_out)
    else $error("posted retry not reissued at same address");
  a_disc_next_dword: assert property (pw_end && tgt_term_i == PBTH_TT_DISC && tgt_left_i |=>
    tgt_reissue_o && tgt_next_addr_o == $past(tgt_addr_i) + {$past(tgt_dwords_i), 2'b00})
    else $error("posted disconnect restart address wrong");
  a_mwi_plain_write: assert property (pw_end && tgt_term_i == PBTH_TT_DISC && tgt_left_i &&
    tgt_cmd_i == PBTH_CMD_MWI && tgt_dwords_i != 16'h0000 |=> tgt_next_cmd_o == PBTH_CMD_MEM_WRITE)
    else $error("partial invalidate write not continued as write");
  a_normal_no_reissue: assert property (pw_end && tgt_term_i == PBTH_TT_NORMAL |=> !tgt_reissue_o)
    else $error("reissue after posted normal end");
  a_reply_one_cycle: assert property (!ini_req_i |=> ini_resp_o == PBTH_RSP_NONE)
    else $error("reply without request");
  a_dw_busy_retry: assert property (ini_req_i && ini_kind_i == PBTH_KIND_DW && dw_busy |=>
    ini_resp_o == PBTH_RSP_RETRY)
    else $error("busy delayed write not retried");
  a_pw_room_retry: assert property (ini_req_i && ini_kind_i == PBTH_KIND_PW && !ini_pw_room_i |=>
    ini_resp_o == PBTH_RSP_RETRY)
    else $error("posted write without room not retried");
  a_rdata_idle: assert property (!reg_read_i |=> reg_rdata_o == 32'h0000_0000)
    else $error("read data outside read cycle");
  a_serr_cause: assert property (primary_system_error_out |-> $past(tgt_end_i))
    else $error("system error without target end");
endmodule // pbth_handler_chk

bind pbth_handler pbth_handler_chk chk_u (.clock_i(clock_i), .srst_i(srst_i), .reg_read_i(reg_read_i),
  .tgt_start_i(tgt_start_i), .tgt_devsel_i(tgt_devsel_i), .tgt_end_i(tgt_end_i), .tgt_left_i(tgt_left_i),
  .tgt_reissue_o(tgt_reissue_o), .tgt_mabort_o(tgt_mabort_o), .ini_req_i(ini_req_i),
  .ini_queueing_i(ini_queueing_i), .ini_queue_full_i(ini_queue_full_i), .ini_dup_i(ini_dup_i),
  .ini_lock_conflict_i(ini_lock_conflict_i), .ini_pw_room_i(ini_pw_room_i),
  .primary_system_error_out(primary_system_error_out), .reg_rdata_o(reg_rdata_o), .tgt_addr_i(tgt_addr_i),
  .tgt_next_addr_o(tgt_next_addr_o), .tgt_cmd_i(tgt_cmd_i), .tgt_next_cmd_o(tgt_next_cmd_o),
  .tgt_dwords_i(tgt_dwords_i), .ini_accept_clocks_i(ini_accept_clocks_i), .tgt_term_i(tgt_term_i),
  .tgt_kind_i(tgt_kind_i), .ini_kind_i(ini_kind_i), .ini_resp_o(ini_resp_o));

// file: sim/pbth_tgt_model.sv
// Purpose: Target-bus agent reporting attempt outcomes
// Assumes: Select is given one cycle after start unless no target answers
// Notes:   Address, command, count and left flag are scrambled outside the end pulse
`timescale 1ns/1ns
module pbth_tgt_model
  import pbth_pkg::*;
(
  input  wire logic   clock_i,
  output logic        start_o = 1'b0,
  output logic        devsel_o = 1'b0,
  output logic        end_o = 1'b0,
  output pbth_term_t  term_o = PBTH_TT_NONE,
  output pbth_kind_t  kind_o = PBTH_KIND_DW,
  output logic [1:0]  entry_o = 2'h0,
  output logic [31:0] addr_o = 32'h0000_0000,
  output logic [3:0]  cmd_o = 4'h0,
  output logic [15:0] dwords_o = 16'h0000,
  output logic        left_o = 1'b0
);
  task automatic attempt(input pbth_term_t t, input pbth_kind_t k, input logic [1:0] e,
                         input logic [31:0] a, input logic [3:0] c, input logic [15:0] n, input logic l);
    @(posedge clock_i) start_o <= 1'b1;
    @(posedge clock_i) start_o <= 1'b0;
    // A target answers with select before any abort
    devsel_o <= 1'b1;
    @(posedge clock_i) end_o <= 1'b1;
    {term_o, kind_o, entry_o} <= {t, k, e};
    {addr_o, cmd_o, dwords_o, left_o} <= {a, c, n, l};
    @(posedge clock_i) end_o <= 1'b0;
    devsel_o <= 1'b0;
    {addr_o, cmd_o, dwords_o, left_o} <= ~{a, c, n, l};
  endtask
  task automatic no_select();
    @(posedge clock_i) start_o <= 1'b1;
    @(posedge clock_i) start_o <= 1'b0;
  endtask
endmodule // pbth_tgt_model

// file: sim/pbth_handler_tb.sv
// Purpose: Self-checking bench for the termination handler
// Assumes: Attempt limit shortened to four
// Notes:   Target side driven by pbth_tgt_model
`timescale 1ns/1ns
module pbth_handler_tb;
  import pbth_pkg::*;
  localparam int LIMIT = 4;
  logic clock_i = 1'b0, srst_i = 1'b1, reg_write = 1'b0, reg_read = 1'b0, ini_req = 1'b0;
  logic [7:0] reg_addr = 8'h00, ini_flags = 8'h80;
  logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, next_addr, taddr;
  logic [1:0] ini_entry = 2'h0, tentry;
  logic [5:0] misc = 6'h00;
  logic [4:0] ini_accept = 5'h00;
  logic [3:0] next_cmd, tcmd;
  logic [15:0] tdw;
  logic reissue, mabort, drop, serr, tstart, tsel, tend, tleft;
  pbth_kind_t ini_kind = PBTH_KIND_DW, tkind;
  pbth_term_t tterm;
  pbth_resp_t resp;
  int n_mismatch = 0, samples_checked = 0, k;
  always #10 clock_i = ~clock_i;
  pbth_tgt_model model_u (.clock_i(clock_i), .start_o(tstart), .devsel_o(tsel), .end_o(tend), .term_o(tterm),
    .kind_o(tkind), .entry_o(tentry), .addr_o(taddr), .cmd_o(tcmd), .dwords_o(tdw), .left_o(tleft));
  pbth_handler #(.RETRY_LIMIT(32'(LIMIT)), .MTO_CLOCKS(8)) dut_u (.clock_i(clock_i), .srst_i(srst_i),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_write_i(reg_write), .reg_read_i(reg_read),
    .reg_rdata_o(reg_rdata), .tgt_start_i(tstart), .tgt_devsel_i(tsel), .tgt_end_i(tend), .tgt_term_i(tterm),
    .tgt_entry_i(tentry), .tgt_kind_i(tkind), .tgt_addr_i(taddr), .tgt_cmd_i(tcmd), .tgt_dwords_i(tdw),
    .tgt_left_i(tleft), .tgt_reissue_o(reissue), .tgt_next_addr_o(next_addr), .tgt_next_cmd_o(next_cmd),
    .tgt_mabort_o(mabort), .ini_req_i(ini_req), .ini_kind_i(ini_kind), .ini_entry_i(ini_entry),
    .ini_multi_i(misc[0]), .ini_prefetch_i(misc[1]), .ini_more_i(misc[2]), .ini_queueing_i(ini_flags[0]),
    .ini_not_ready_i(ini_flags[1]), .ini_queue_full_i(ini_flags[2]), .ini_dup_i(ini_flags[3]),
    .ini_lock_conflict_i(ini_flags[4]), .ini_behind_post_i(ini_flags[5]), .ini_discarding_i(ini_flags[6]),
    .ini_pw_room_i(ini_flags[7]), .ini_boundary_i(misc[3]), .ini_no_space_i(misc[4]), .ini_no_data_i(misc[5]),
    .ini_accept_clocks_i(ini_accept), .ini_resp_o(resp), .ini_entry_drop_o(drop),
    .primary_system_error_out(serr));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i) {reg_write, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge clock_i) reg_write <= 1'b0;
  endtask
  task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock_i) {reg_read, reg_addr} <= {1'b1, a};
    @(posedge clock_i) reg_read <= 1'b0;
    #1 chk(what, exp, reg_rdata);
  endtask
  task automatic ini(input pbth_kind_t kd, input logic [1:0] e, input logic [7:0] f, input logic [4:0] ac);
    @(posedge clock_i) {ini_req, ini_kind, ini_entry, ini_flags, ini_accept} <= {1'b1, kd, e, f, ac};
    @(posedge clock_i) {ini_req, ini_flags, ini_accept} <= {1'b0, 8'h80, 5'h00};
    #1;
  endtask
  task automatic t_regs();
    rd("mask reset", PBTH_REG_EVT_MASK, 32'(PBTH_MASK_RESET));
    rd("limit reset", PBTH_REG_LIMIT, 32'(LIMIT));
    wr(8'h44, 32'hffff_ffff);
    rd("unmapped", 8'h44, 32'h0000_0000);
    wr(PBTH_REG_EVT_MASK, 32'h0000_0024);
    rd("mask", PBTH_REG_EVT_MASK, 32'h0000_0024);
    wr(PBTH_REG_LIMIT, 32'h0000_0000);
    rd("limit zero", PBTH_REG_LIMIT, 32'h0000_0001);
    wr(PBTH_REG_LIMIT, 32'(LIMIT));
  endtask
  task automatic t_posted();
    model_u.attempt(PBTH_TT_RETRY, PBTH_KIND_PW, 2'h0, 32'h0000_1000, PBTH_CMD_MEM_WRITE, 16'h0000, 1'b1);
    #1 chk("retry reissue", 32'h1, 32'(reissue));
    chk("retry addr", 32'h0000_1000, next_addr);
    rd("attempts", PBTH_REG_ATTEMPTS, 32'h0000_0001);
    model_u.attempt(PBTH_TT_DISC, PBTH_KIND_PW, 2'h0, 32'h0000_2000, PBTH_CMD_MWI, 16'h0003, 1'b1);
    #1 chk("disc addr", 32'h0000_200c, next_addr);
    chk("disc cmd", 32'(PBTH_CMD_MEM_WRITE), 32'(next_cmd));
    model_u.attempt(PBTH_TT_NORMAL, PBTH_KIND_PW, 2'h0, 32'h0000_200c, PBTH_CMD_MEM_WRITE, 16'h0001, 1'b0);
    #1 chk("normal reissue", 32'h0, 32'(reissue));
    rd("attempts cleared", PBTH_REG_ATTEMPTS, 32'h0000_0000);
  endtask
  // Entry 3 only; the handler clears its count when the limit is reached
  task automatic t_exhaust(input pbth_kind_t kd, input logic [31:0] cmd, input logic [31:0] mask, input logic ex);
    wr(PBTH_REG_CMD, cmd);
    wr(PBTH_REG_EVT_MASK, mask);
    for (int i = 0; i < LIMIT; i++) begin
      model_u.attempt(PBTH_TT_RETRY, kd, 2'h3, 32'h0000_3000, PBTH_CMD_MEM_WRITE, 16'h0000, 1'b1);
      #1 chk("system error", 32'(ex && i == LIMIT - 1), 32'(serr));
    end
  endtask
  task automatic t_refuse();
    for (int b = 0; b < 5; b++) begin
      ini(PBTH_KIND_DW, 2'h1, 8'h80 | 8'(1 << b), 5'h00);
      chk("dw retry", 32'(PBTH_RSP_RETRY), 32'(resp));
    end
    ini(PBTH_KIND_DW, 2'h1, 8'h80, 5'd17);
    chk("dw slow", 32'(PBTH_RSP_RETRY), 32'(resp));
    for (int b = 0; b < 7; b++) begin
      ini(PBTH_KIND_DR, 2'h2, 8'h80 | 8'(1 << b), 5'h00);
      chk("dr retry", 32'(PBTH_RSP_RETRY), 32'(resp));
    end
    ini(PBTH_KIND_PW, 2'h0, 8'h00, 5'h00);
    chk("pw room", 32'(PBTH_RSP_RETRY), 32'(resp));
  endtask
  task automatic t_abort(input pbth_kind_t kd, input logic [1:0] e, input logic [31:0] st);
    wr(PBTH_REG_STATUS, 32'h0000_000f);
    model_u.attempt(PBTH_TT_TABORT, kd, e, 32'h0000_4000, PBTH_CMD_MEM_WRITE, 16'h0000, 1'b1);
    #1 if (kd == PBTH_KIND_PW) chk("abort serr", 32'h1, 32'(serr));
    if (kd != PBTH_KIND_PW) begin
      ini(kd, e, 8'h80, 5'h00);
      chk("abort reply", 32'(PBTH_RSP_TABORT), 32'(resp));
      chk("abort drop", 32'h1, 32'(drop));
    end
    rd("abort status", PBTH_REG_STATUS, st);
  endtask
  // Completed delayed entries: reply shape depends on what the initiator asks
  task automatic t_done();
    model_u.attempt(PBTH_TT_NORMAL, PBTH_KIND_DW, 2'h2, 32'h0000_5000, PBTH_CMD_MEM_WRITE, 16'h0001, 1'b0);
    @(posedge clock_i) misc <= 6'h01;
    ini(PBTH_KIND_DW, 2'h2, 8'h80, 5'h00);
    chk("dw multi", 32'(PBTH_RSP_DATA_DISC), 32'(resp));
    model_u.attempt(PBTH_TT_NORMAL, PBTH_KIND_DR, 2'h2, 32'h0000_6000, 4'h6, 16'h0001, 1'b0);
    ini(PBTH_KIND_DR, 2'h2, 8'h80, 5'h00);
    chk("dr first phase", 32'(PBTH_RSP_DATA_DISC), 32'(resp));
    model_u.attempt(PBTH_TT_DISC, PBTH_KIND_DR, 2'h2, 32'h0000_7000, 4'h6, 16'h0001, 1'b0);
    @(posedge clock_i) misc <= 6'h00;
    ini(PBTH_KIND_DR, 2'h2, 8'h80, 5'h00);
    chk("dr disc", 32'(PBTH_RSP_DATA), 32'(resp));
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #200000;
    n_mismatch++;
    end_of_test();
  end
  initial begin
    repeat (6) @(posedge clock_i);
    srst_i <= 1'b0;
    t_regs();
    t_posted();
    t_refuse();
    t_exhaust(PBTH_KIND_DW, 32'h0000_0100, 32'h0000_0000, 1'b1);
    t_exhaust(PBTH_KIND_DW, 32'h0000_0100, 32'h0000_0020, 1'b0);
    t_exhaust(PBTH_KIND_DW, 32'h0000_0000, 32'h0000_0000, 1'b0);
    t_exhaust(PBTH_KIND_PW, 32'h0000_0100, 32'h0000_0000, 1'b1);
    t_exhaust(PBTH_KIND_DR, 32'h0000_0100, 32'h0000_0000, 1'b1);
    t_exhaust(PBTH_KIND_DR, 32'h0000_0100, 32'h0000_0020, 1'b0);
    t_abort(PBTH_KIND_PW, 2'h1, 32'h0000_0005);
    t_abort(PBTH_KIND_DW, 2'h1, 32'h0000_0003);
    t_abort(PBTH_KIND_DR, 2'h2, 32'h0000_0003);
    t_done();
    model_u.no_select();
    k = 0;
    for (int i = 1; i <= 8; i++) begin
      @(posedge clock_i) #1 if (mabort === 1'b1 && k == 0) k = i;
    end
    chk("mabort cycle", 32'(PBTH_DEVSEL_CLOCKS - 1), 32'(k));
    rd("mabort status", PBTH_REG_STATUS, 32'h0000_000b);
    end_of_test();
  end
endmodule // pbth_handler_tb
